/* include/dpot_pkg.sv */
// types and decode functions of the dual potentiometer two-wire slave
`default_nettype none
`include "dpot_two_wire_regs.svh"
package dpot_pkg;
    typedef enum logic [3:0] {
        dpot_idle, dpot_addr, dpot_addr_ack, dpot_instr, dpot_instr_ack,
        dpot_wdata, dpot_wdata_ack, dpot_rdata, dpot_rdata_ack, dpot_wait_stop
    } dpot_state_type;

    typedef struct packed {
        logic [3:0] opcode;
        logic       setting_select_hi;
        logic       setting_select_lo;
        logic       pot_select_hi;
        logic       pot_select_lo;
    } dpot_instr_type;

    typedef struct packed {
        logic           commit;
        dpot_instr_type instr;
        logic [7:0]     data;
    } dpot_cmd_type;

    function automatic logic dpot_is_stored_write(input logic [3:0] op);
        return (op == `DPOT_OP_WR_STORED) || (op == `DPOT_OP_XFR_TO_STORED)
            || (op == `DPOT_OP_GANG_TO_STORED);
    endfunction : dpot_is_stored_write

    function automatic logic dpot_is_read(input logic [3:0] op);
        return (op == `DPOT_OP_RD_WIPER) || (op == `DPOT_OP_RD_STORED);
    endfunction : dpot_is_read

    function automatic logic dpot_is_data_write(input logic [3:0] op);
        return (op == `DPOT_OP_WR_WIPER) || (op == `DPOT_OP_WR_STORED);
    endfunction : dpot_is_data_write

    function automatic logic dpot_is_two_byte(input logic [3:0] op);
        return (op == `DPOT_OP_XFR_TO_WIPER) || (op == `DPOT_OP_XFR_TO_STORED)
            || (op == `DPOT_OP_GANG_TO_WIPER) || (op == `DPOT_OP_GANG_TO_STORED);
    endfunction : dpot_is_two_byte

    function automatic logic [2:0] dpot_stored_index(input logic pot,
                                                     input logic [1:0] sel);
        return {pot, sel};
    endfunction : dpot_stored_index

    function automatic logic [255:0] dpot_tap_decode(input logic [7:0] w);
        return `DPOT_TAP_ONE << w;
    endfunction : dpot_tap_decode
endpackage : dpot_pkg
`default_nettype wire

/* include/dpot_two_wire_regs.svh */
// constants of the dual potentiometer two-wire slave
`ifndef DPOT_TWO_WIRE_REGS_SVH
`define DPOT_TWO_WIRE_REGS_SVH
`define DPOT_BITS_PER_BYTE      4'h8
`define DPOT_COUNT_ONE          4'h1
`define DPOT_COUNT_ZERO         4'h0
`define DPOT_ZERO_BYTE          8'h00
`define DPOT_ADDR_ID_HI         7
`define DPOT_ADDR_ID_LO         4
`define DPOT_ADDR_STRAP_HI      3
`define DPOT_ADDR_STRAP_LO      0
`define DPOT_NUM_POTS           2
`define DPOT_NUM_STORED         8
`define DPOT_SETTING_FIRST      2'h0
`define DPOT_STORED_INIT        8'h80
`define DPOT_TAP_ONE            256'h1
`define DPOT_CLOCK_KHZ          25000
`define DPOT_WRITE_CYCLE_US     5000
`define DPOT_WRITE_CYCLE_CYCLES (`DPOT_WRITE_CYCLE_US * `DPOT_CLOCK_KHZ / 1000)
`define DPOT_TIMER_ONE          17'h0_0001
`define DPOT_TIMER_ZERO         17'h0_0000
`define DPOT_OP_RD_WIPER        4'h9
`define DPOT_OP_WR_WIPER        4'ha
`define DPOT_OP_RD_STORED       4'hb
`define DPOT_OP_WR_STORED       4'hc
`define DPOT_OP_XFR_TO_WIPER    4'hd
`define DPOT_OP_XFR_TO_STORED   4'he
`define DPOT_OP_GANG_TO_WIPER   4'h1
`define DPOT_OP_GANG_TO_STORED  4'h8
`endif

/* sim/dpot_chk.sv */
// port assertions of the potentiometer two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "dpot_two_wire_regs.svh"
module dpot_chk #(
    parameter int WRITE_CYCLE_CYCLES = `DPOT_WRITE_CYCLE_CYCLES
)(
    input wire logic             clock,
    input wire logic             rstn,
    input wire logic             link_clock,
    input wire logic             scl,
    input wire logic             sda_oe_n,
    input wire logic [1:0][7:0]   wiper_setting_reg,
    input wire logic [1:0][255:0] tap_select,
    input wire logic             write_busy
);
    int busy_cnt;
    always_ff @(posedge clock or negedge rstn)
        if (!rstn)
            busy_cnt <= 0;
        else
            busy_cnt <= write_busy ? busy_cnt + 1 : 0;
    property p_tap;
        @(posedge clock) disable iff (!rstn) $past(rstn) |->
            tap_select[0] == 256'h1 << $past(wiper_setting_reg[0])
            && tap_select[1] == 256'h1 << $past(wiper_setting_reg[1]);
    endproperty
    a_tap: assert property (p_tap) else $error("tap not one-hot of wiper");
    property p_init;
        @(posedge clock) disable iff (!rstn)
            !$past(rstn) |=> wiper_setting_reg == {2{`DPOT_STORED_INIT}};
    endproperty
    a_init: assert property (p_init) else $error("wiper not restored");
    property p_busy_len;
        @(posedge clock) disable iff (!rstn) write_busy |-> busy_cnt <= WRITE_CYCLE_CYCLES;
    endproperty
    a_busy_len: assert property (p_busy_len) else $error("write cycle too long");
    property p_busy_start;
        @(posedge clock) disable iff (!rstn) $rose(write_busy) |-> scl;
    endproperty
    a_busy_start: assert property (p_busy_start) else $error("cycle not at stop");
    property p_wiper_quiet;
        @(posedge clock) disable iff (!rstn) !$stable(wiper_setting_reg) |-> scl;
    endproperty
    a_wiper_quiet: assert property (p_wiper_quiet) else $error("wiper moved mid-bit");
    property p_busy_quiet;
        @(posedge link_clock) disable iff (!rstn) write_busy |-> sda_oe_n;
    endproperty
    a_busy_quiet: assert property (p_busy_quiet) else $error("drive while busy");
    property p_oe_stable;
        @(posedge link_clock) disable iff (!rstn) scl && $past(scl) |-> $stable(sda_oe_n);
    endproperty
    a_oe_stable: assert property (p_oe_stable) else $error("data moved, clock high");
    property p_drive_hold;
        @(posedge link_clock) disable iff (!rstn) $fell(sda_oe_n) |-> !scl ##1 (!sda_oe_n)[*8];
    endproperty
    a_drive_hold: assert property (p_drive_hold) else $error("low drive too short");
endmodule : dpot_chk
bind dpot_two_wire_slave dpot_chk #(.WRITE_CYCLE_CYCLES(WRITE_CYCLE_CYCLES)) dpot_chk_inst (
    .clock(clock), .rstn(rstn), .link_clock(link_clock), .scl(scl), .sda_oe_n(sda_oe_n),
    .wiper_setting_reg(wiper_setting_reg), .tap_select(tap_select), .write_busy(write_busy)
);
`default_nettype wire

/* sim/dpot_master.sv */
// two-wire bus master model that clocks every transfer
`timescale 1ns/1ps
`default_nettype none
module dpot_master (
    input  wire logic clock,
    input  wire logic sda,
    output var  logic scl,
    output var  logic sda_m
);
    initial scl = 1'b1;
    initial sda_m = 1'b1;
    task automatic q(input int n);
        repeat (n * 16) @(negedge clock);
    endtask : q
    // b high: start from idle, b low: stop
    task automatic cond(input logic b);
        sda_m = b;
        q(1);
        scl = 1'b1;
        q(2);
        sda_m = ~b;
        q(2);
        scl = ~b;
    endtask : cond
    task automatic bit_io(input logic b, output logic s);
        q(1);
        sda_m = b;
        q(1);
        scl = 1'b1;
        q(1);
        s = sda;
        q(1);
        scl = 1'b0;
    endtask : bit_io
    task automatic xbyte(input logic [7:0] d, input logic mack, output logic [7:0] r,
                         output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--)
            bit_io(d[i], r[i]);
        bit_io(~mack, s);
        ack = ~s;
    endtask : xbyte
    // nb of 1 to 3 writes bytes, 4 reads two bytes after the instruction
    task automatic frame(input logic [7:0] a, i, d, input int nb, output logic [2:0] k,
                         output logic [15:0] rb, output logic rel);
        logic [7:0] r;
        k = 3'b000;
        cond(1'b1);
        xbyte(a, 1'b0, r, k[2]);
        if (nb > 1)
            xbyte(i, 1'b0, r, k[1]);
        q(2);
        if (nb == 3)
            xbyte(d, 1'b0, r, k[0]);
        if (nb == 4)
            xbyte(8'hff, 1'b1, rb[15:8], k[0]);
        if (nb == 4)
            xbyte(8'hff, 1'b0, rb[7:0], k[0]);
        q(1);
        rel = sda;
        cond(1'b0);
    endtask : frame
endmodule : dpot_master
`default_nettype wire

/* sim/test_dual_pot_two_wire_slave.sv */
// self-checking bench of the potentiometer two-wire slave
`timescale 1ns/1ps
`default_nettype none
`include "dpot_two_wire_regs.svh"
module test_dual_pot_two_wire_slave;
    localparam logic [3:0] ID = 4'h9; // arbitrary value
    logic              clock, link_clock, rstn, wp_n, scl, sda_m, sda_out, sda_oe_n;
    logic              busy, rel;
    logic [3:0]        strap;
    logic [7:0]        adr;
    logic [2:0]        k;
    logic [15:0]       rb;
    logic [1:0][7:0]   wiper;
    logic [1:0][255:0] tap;
    int                failures, compares;
    wire logic         sda = sda_m & (sda_oe_n | sda_out);
    assign adr = {ID, strap};
    dpot_two_wire_slave #(.WRITE_CYCLE_CYCLES(2000), .DEVICE_TYPE_ID(ID))
        dpot_two_wire_slave_inst (
        .clock(clock), .rstn(rstn), .link_clock(link_clock), .scl(scl), .sda_in(sda),
        .sda_out(sda_out), .sda_oe_n(sda_oe_n), .addr_strap_bit0(strap[0]),
        .addr_strap_bit1(strap[1]), .addr_strap_bit2(strap[2]), .addr_strap_bit3(strap[3]),
        .wp_n(wp_n), .wiper_setting_reg(wiper), .tap_select(tap), .write_busy(busy)
    );
    dpot_master dpot_master_inst (.clock(clock), .sda(sda), .scl(scl), .sda_m(sda_m));
    initial
    begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    initial
    begin
        link_clock = 1'b0;
        #3.7;
        forever #6 link_clock = ~link_clock;
    end
    task automatic chk(input string nm, input logic [255:0] s, e);
        compares++;
        if (s !== e)
        begin
            failures++;
            $display("[ERR] %s expected %0h seen %0h", nm, e, s);
        end
    endtask : chk
    task automatic give_verdict;
        if (failures == 0 && compares > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask : give_verdict
    task automatic go(input logic [7:0] a, i, d, input int nb);
        dpot_master_inst.frame(a, i, d, nb, k, rb, rel);
    endtask : go
    task automatic poll;
        int n;
        n = 0;
        k = 3'b000;
        while (k[2] !== 1'b1 && n < 20)
        begin
            go(adr, 8'h00, 8'h00, 1);
            n++;
        end
        chk("poll_busy", n > 1, 1'b1);
        chk("poll_ack", k[2], 1'b1);
    endtask : poll
    task automatic s_addr;
        strap = 4'h9;
        @(negedge clock);
        go(adr, 8'h00, 8'h00, 1);
        chk("strap_ack", k[2], 1'b1);
        strap = 4'h6;
        @(negedge clock);
        go(adr ^ 8'h01, 8'ha0, 8'h11, 3);
        chk("strap_nack", k, 3'b000);
        go(adr ^ 8'h40, 8'ha0, 8'h11, 3);
        chk("id_nack", k, 3'b000);
        chk("no_write", wiper[0], `DPOT_STORED_INIT);
    endtask : s_addr
    task automatic s_wiper;
        go(adr, 8'ha1, 8'h3c, 3);
        chk("wr_acks", k, 3'b111);
        repeat (250) @(negedge clock);
        chk("wiper1", wiper[1], 8'h3c);
        chk("tap1", tap[1], 256'h1 << 8'h3c);
        chk("no_busy", busy, 1'b0);
        go(adr, 8'h00, 8'h00, 1);
        chk("fast_ack", k[2], 1'b1);
    endtask : s_wiper
    task automatic s_stored;
        go(adr, 8'hc4, 8'h5a, 3);
        chk("nv_acks", k, 3'b111);
        chk("nv_busy", busy, 1'b1);
        poll();
        go(adr, 8'hb4, 8'h00, 4);
        chk("rd_bytes", rb, 16'h5a5a);
        chk("rd_release", rel, 1'b1);
        go(adr, 8'hd4, 8'h00, 2);
        repeat (250) @(negedge clock);
        chk("xfr_wiper", wiper[0], 8'h5a);
        go(adr, 8'h14, 8'h00, 2);
        go(adr, 8'h91, 8'h00, 4);
        chk("gang_wiper", wiper, 16'h805a);
        chk("rd_wiper", rb[15:8], 8'h80);
    endtask : s_stored
    task automatic s_wp;
        fork
            go(adr, 8'hc8, 8'h77, 3);
            begin
                repeat (300) @(negedge clock);
                wp_n = 1'b0;
            end
        join
        chk("wp_acks", k, 3'b110);
        chk("wp_busy", busy, 1'b0);
        go(adr, 8'hb8, 8'h00, 4);
        chk("wp_kept", rb[15:8], `DPOT_STORED_INIT);
        wp_n = 1'b1;
        go(adr, 8'hc8, 8'h77, 3);
        wp_n = 1'b0;
        poll();
        go(adr, 8'hb8, 8'h00, 4);
        chk("wp_late", rb[15:8], 8'h77);
        wp_n = 1'b1;
    endtask : s_wp
    initial
    begin
        failures = 0;
        compares = 0;
        rstn = 1'b0;
        wp_n = 1'b1;
        strap = 4'h6;
        repeat (2) @(negedge clock);
        rstn = 1'b1;
        repeat (25000) @(negedge clock);
        chk("wiper_init", wiper, {2{`DPOT_STORED_INIT}});
        chk("tap_init", tap[0], 256'h1 << `DPOT_STORED_INIT);
        s_addr();
        s_wiper();
        s_stored();
        s_wp();
        give_verdict();
    end
    initial
    begin
        repeat (95000) @(posedge clock);
        failures++;
        give_verdict();
    end
endmodule : test_dual_pot_two_wire_slave
`default_nettype wire

/* src/dpot_two_wire_slave.sv */
// two-wire slave, register store and write cycle of the dual potentiometer
`timescale 1ns/1ps
`default_nettype none
`include "dpot_two_wire_regs.svh"
// Behaviour
// - data change during clock high is START/STOP
// - START is data falling, ignore until seen
// - STOP is data rising; detected, closes operation
// - address: identifier nibble plus four strap bits
// - acknowledge address only on full match
// - receiver pulls data low on ninth clock
// - write mode acknowledges address, instruction and one data byte
// - read mode: send byte, sample acknowledge, repeat
// - no master acknowledge: release, await STOP
// - stored write STOP starts programming, ignore master
// - programming lasts 5 ms, address unacknowledged
// - polling acknowledged once programming is done
// - write protect low: nack stored-write data, no programming
// - protect low before cycle aborts; after, continues
// - wiper follows instruction within 10 us
// - wiper restored within 10 us of power up
// - power up loads wiper from first stored setting
// - wiper value closes exactly one of 256 taps
// - instruction: opcode, setting select, pot select
module dpot_two_wire_slave
    import dpot_pkg::*;
#(
    parameter int         WRITE_CYCLE_CYCLES = `DPOT_WRITE_CYCLE_CYCLES,
    parameter logic [3:0] DEVICE_TYPE_ID     = 4'h9 // arbitrary value
)(
    input  wire logic                  clock,
    input  wire logic                  rstn,
    input  wire logic                  link_clock,
    input  wire logic                  scl,
    input  wire logic                  sda_in,
    output var  logic                  sda_out,
    output var  logic                  sda_oe_n,
    input  wire logic                  addr_strap_bit0,
    input  wire logic                  addr_strap_bit1,
    input  wire logic                  addr_strap_bit2,
    input  wire logic                  addr_strap_bit3,
    input  wire logic                  wp_n,
    output var  logic [1:0][7:0]       wiper_setting_reg,
    output var  logic [1:0][255:0]     tap_select,
    output var  logic                  write_busy
);
    localparam logic [16:0] WRITE_CYCLE_LOAD = 17'(WRITE_CYCLE_CYCLES);

    // link domain
    logic           scl_s1, scl_s2, scl_p;
    logic           sda_s1, sda_s2, sda_p;
    logic           wp_s1, wp_s2;
    logic [3:0]     strap_s1, strap_s2;
    logic           ack_s1, ack_s2;
    logic           busy_s1, busy_s2;
    logic [7:0]     rb_s1, rb_s2;
    dpot_state_type state;
    logic [3:0]     bit_count;
    logic [7:0]     shift_in;
    logic [7:0]     tx_shift;
    logic [7:0]     data_byte;
    dpot_instr_type instr;
    logic           master_ack;
    logic           cmd_ready;
    logic           wp_abort;
    logic           req_toggle;
    dpot_cmd_type   req_word;
    // system domain
    logic           req_s1, req_s2, req_s3;
    logic           ack_toggle;
    dpot_instr_type read_sel;
    logic [7:0]     read_byte;
    logic [7:0]     stored_setting_reg [`DPOT_NUM_STORED];
    logic [16:0]    timer;
    logic           restore;

    logic scl_rise, scl_fall, start_seen, stop_seen, byte_done;
    logic addr_match, req_pending, link_busy, instr_done, commit_ok;
    logic take, exec, pot;
    logic [2:0] idx;
    logic [2:0] idx0;
    logic [2:0] idx1;

    assign scl_rise    = scl_s2 && !scl_p;
    assign scl_fall    = !scl_s2 && scl_p;
    assign start_seen  = scl_s2 && scl_p && sda_p && !sda_s2;
    assign stop_seen   = scl_s2 && scl_p && !sda_p && sda_s2;
    assign byte_done   = scl_fall && (bit_count == `DPOT_BITS_PER_BYTE);
    assign addr_match  = (shift_in[`DPOT_ADDR_ID_HI:`DPOT_ADDR_ID_LO] == DEVICE_TYPE_ID)
                      && (shift_in[`DPOT_ADDR_STRAP_HI:`DPOT_ADDR_STRAP_LO] == strap_s2);
    assign req_pending = req_toggle != ack_s2;
    assign link_busy   = req_pending || busy_s2;
    assign instr_done  = byte_done && (state == dpot_instr) && !start_seen && !stop_seen;
    assign commit_ok   = cmd_ready && !(wp_abort && dpot_is_stored_write(instr.opcode));

    always_ff @(posedge link_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            {scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p} <= 6'h3f;
            {wp_s1, wp_s2, ack_s1, ack_s2, busy_s1, busy_s2} <= 6'h30;
            strap_s1 <= 4'h0;
            strap_s2 <= 4'h0;
            rb_s1    <= `DPOT_ZERO_BYTE;
            rb_s2    <= `DPOT_ZERO_BYTE;
        end
        else
        begin
            {scl_s1, scl_s2, scl_p} <= {scl, scl_s1, scl_s2};
            {sda_s1, sda_s2, sda_p} <= {sda_in, sda_s1, sda_s2};
            {wp_s1, wp_s2}          <= {wp_n, wp_s1};
            {ack_s1, ack_s2}        <= {ack_toggle, ack_s1};
            {busy_s1, busy_s2}      <= {write_busy, busy_s1};
            strap_s1 <= {addr_strap_bit3, addr_strap_bit2, addr_strap_bit1, addr_strap_bit0};
            strap_s2 <= strap_s1;
            rb_s1    <= read_byte;
            rb_s2    <= rb_s1;
        end
    end

    always_ff @(posedge link_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            state      <= dpot_idle;
            bit_count  <= `DPOT_COUNT_ZERO;
            shift_in   <= `DPOT_ZERO_BYTE;
            tx_shift   <= `DPOT_ZERO_BYTE;
            data_byte  <= `DPOT_ZERO_BYTE;
            instr      <= '0;
            master_ack <= 1'b0;
            cmd_ready  <= 1'b0;
            sda_oe_n   <= 1'b1;
            sda_out    <= 1'b0;
        end
        else if (start_seen)
        begin
            state     <= dpot_addr;
            bit_count <= `DPOT_COUNT_ZERO;
            cmd_ready <= 1'b0;
            sda_oe_n  <= 1'b1;
        end
        else if (stop_seen)
        begin
            state     <= dpot_idle;
            cmd_ready <= 1'b0;
            sda_oe_n  <= 1'b1;
        end
        else
        begin
            case (state)
                dpot_addr, dpot_instr, dpot_wdata:
                begin
                    if (scl_rise)
                    begin
                        shift_in  <= {shift_in[6:0], sda_s2};
                        bit_count <= bit_count + `DPOT_COUNT_ONE;
                    end
                    else if (byte_done)
                    begin
                        bit_count <= `DPOT_COUNT_ZERO;
                        case (state)
                            dpot_addr:
                            begin
                                if (addr_match && !link_busy)
                                begin
                                    sda_oe_n <= 1'b0;
                                    state    <= dpot_addr_ack;
                                end
                                else
                                begin
                                    state <= dpot_wait_stop;
                                end
                            end
                            dpot_instr:
                            begin
                                instr    <= shift_in;
                                sda_oe_n <= 1'b0;
                                state    <= dpot_instr_ack;
                            end
                            default:
                            begin
                                data_byte <= shift_in;
                                if (wp_abort && dpot_is_stored_write(instr.opcode))
                                begin
                                    state <= dpot_wait_stop;
                                end
                                else
                                begin
                                    sda_oe_n <= 1'b0;
                                    state    <= dpot_wdata_ack;
                                end
                            end
                        endcase
                    end
                end
                dpot_addr_ack:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_n <= 1'b1;
                        state    <= dpot_instr;
                    end
                end
                dpot_instr_ack:
                begin
                    if (scl_fall)
                    begin
                        if (dpot_is_read(instr.opcode))
                        begin
                            sda_oe_n <= rb_s2[7];
                            tx_shift <= {rb_s2[6:0], 1'b0};
                            state    <= dpot_rdata;
                        end
                        else if (dpot_is_two_byte(instr.opcode))
                        begin
                            sda_oe_n  <= 1'b1;
                            cmd_ready <= 1'b1;
                            state     <= dpot_wait_stop;
                        end
                        else if (dpot_is_data_write(instr.opcode))
                        begin
                            sda_oe_n <= 1'b1;
                            state    <= dpot_wdata;
                        end
                        else
                        begin
                            sda_oe_n <= 1'b1;
                            state    <= dpot_wait_stop;
                        end
                    end
                end
                dpot_wdata_ack:
                begin
                    if (scl_fall)
                    begin
                        sda_oe_n  <= 1'b1;
                        cmd_ready <= 1'b1;
                        state     <= dpot_wait_stop;
                    end
                end
                dpot_rdata:
                begin
                    if (scl_rise)
                    begin
                        bit_count <= bit_count + `DPOT_COUNT_ONE;
                    end
                    else if (byte_done)
                    begin
                        sda_oe_n  <= 1'b1;
                        bit_count <= `DPOT_COUNT_ZERO;
                        state     <= dpot_rdata_ack;
                    end
                    else if (scl_fall)
                    begin
                        sda_oe_n <= tx_shift[7];
                        tx_shift <= {tx_shift[6:0], 1'b0};
                    end
                end
                dpot_rdata_ack:
                begin
                    if (scl_rise)
                    begin
                        master_ack <= !sda_s2;
                    end
                    else if (scl_fall)
                    begin
                        if (master_ack)
                        begin
                            sda_oe_n <= rb_s2[7];
                            tx_shift <= {rb_s2[6:0], 1'b0};
                            state    <= dpot_rdata;
                        end
                        else
                        begin
                            state <= dpot_wait_stop;
                        end
                    end
                end
                default:
                begin
                    sda_oe_n <= 1'b1;
                end
            endcase
        end
    end

    // protect level seen low at any time from START until STOP
    always_ff @(posedge link_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            wp_abort <= 1'b0;
        end
        else if (start_seen)
        begin
            wp_abort <= !wp_s2;
        end
        else if (!wp_s2 && state != dpot_idle)
        begin
            wp_abort <= 1'b1;
        end
    end

    // requests to the system domain: read select and commit
    always_ff @(posedge link_clock or negedge rstn)
    begin
        if (!rstn)
        begin
            req_toggle <= 1'b0;
            req_word   <= '0;
        end
        else if (!req_pending && instr_done)
        begin
            req_word   <= {1'b0, shift_in, data_byte};
            req_toggle <= !req_toggle;
        end
        else if (!req_pending && stop_seen && commit_ok)
        begin
            req_word   <= {1'b1, instr, data_byte};
            req_toggle <= !req_toggle;
        end
    end

    // system domain
    assign take = req_s2 != req_s3;
    assign exec = take && req_word.commit;
    assign pot  = req_word.instr.pot_select_lo;
    assign idx  = dpot_stored_index(pot, {req_word.instr.setting_select_hi,
                                          req_word.instr.setting_select_lo});
    assign idx0 = dpot_stored_index(1'b0, idx[1:0]);
    assign idx1 = dpot_stored_index(1'b1, idx[1:0]);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            {req_s1, req_s2, req_s3} <= 3'h0;
            ack_toggle <= 1'b0;
            read_sel   <= '0;
        end
        else
        begin
            {req_s1, req_s2, req_s3} <= {req_toggle, req_s1, req_s2};
            if (take)
            begin
                ack_toggle <= req_s2;
                if (!req_word.commit)
                begin
                    read_sel <= req_word.instr;
                end
            end
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            restore           <= 1'b1;
            wiper_setting_reg <= '0;
        end
        else if (restore)
        begin
            restore <= 1'b0;
            for (int p = 0; p < `DPOT_NUM_POTS; p++)
            begin
                wiper_setting_reg[p] <= stored_setting_reg[
                    dpot_stored_index(1'(p), `DPOT_SETTING_FIRST)];
            end
        end
        else if (exec)
        begin
            case (req_word.instr.opcode)
                `DPOT_OP_WR_WIPER:      wiper_setting_reg[pot] <= req_word.data;
                `DPOT_OP_XFR_TO_WIPER:  wiper_setting_reg[pot] <= stored_setting_reg[idx];
                `DPOT_OP_GANG_TO_WIPER:
                begin
                    wiper_setting_reg[0] <= stored_setting_reg[idx0];
                    wiper_setting_reg[1] <= stored_setting_reg[idx1];
                end
                default:                ;
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            for (int i = 0; i < `DPOT_NUM_STORED; i++)
            begin
                stored_setting_reg[i] <= `DPOT_STORED_INIT;
            end
            write_busy <= 1'b0;
            timer      <= `DPOT_TIMER_ZERO;
        end
        else if (write_busy)
        begin
            timer <= timer - `DPOT_TIMER_ONE;
            if (timer == `DPOT_TIMER_ONE)
            begin
                write_busy <= 1'b0;
            end
        end
        else if (exec && dpot_is_stored_write(req_word.instr.opcode))
        begin
            write_busy <= 1'b1;
            timer      <= WRITE_CYCLE_LOAD;
            case (req_word.instr.opcode)
                `DPOT_OP_WR_STORED:    stored_setting_reg[idx] <= req_word.data;
                `DPOT_OP_XFR_TO_STORED: stored_setting_reg[idx] <= wiper_setting_reg[pot];
                default:
                begin
                    stored_setting_reg[idx0] <= wiper_setting_reg[0];
                    stored_setting_reg[idx1] <= wiper_setting_reg[1];
                end
            endcase
        end
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            read_byte  <= `DPOT_ZERO_BYTE;
            tap_select <= '0;
        end
        else
        begin
            read_byte <= (read_sel.opcode == `DPOT_OP_RD_WIPER)
                ? wiper_setting_reg[read_sel.pot_select_lo]
                : stored_setting_reg[dpot_stored_index(read_sel.pot_select_lo,
                      {read_sel.setting_select_hi, read_sel.setting_select_lo})];
            for (int p = 0; p < `DPOT_NUM_POTS; p++)
            begin
                tap_select[p] <= dpot_tap_decode(wiper_setting_reg[p]);
            end
        end
    end
endmodule : dpot_two_wire_slave
`default_nettype wire
